// ### shared/motor_io_map.vh
// register map, field positions and timing constants of the motor status and control logic
// assumes a 40 MHz core clock; included by bare name from the rtl files
`ifndef MOTOR_IO_MAP_VH
`define MOTOR_IO_MAP_VH
`define CLK_HZ              40000000
`define PULSE_WIDTH_US      200
`define PULSE_CYCLES        ((`CLK_HZ / 1000000) * `PULSE_WIDTH_US)
`define PULSES_PER_REV      30
`define CLEAR_HOLD_MS       10
`define CLEAR_HOLD_CYCLES   ((`CLK_HZ / 1000) * `CLEAR_HOLD_MS)
// sized counter limits: PULSE_CYCLES less one, and CLEAR_HOLD_CYCLES
`define PULSE_LOAD          16'h1F3F
`define CLEAR_HOLD_LIMIT    19'h61A80
`define ADDR_CTRL           12'h000
`define ADDR_CLAMP_MAP      12'h004
`define ADDR_NET_CMD        12'h008
`define ADDR_PASS_MAP       12'h00C
`define ADDR_STATUS         12'h010
`define ADDR_NET_STAT       12'h014
`define ADDR_ECHO           12'h018
`define ADDR_SPEED_CMD      12'h01C
`define CTRL_OVL_WARN_EN    0
`define CTRL_BRAKE_AFTER    1
`define CTRL_BRAKE_MOTOR    2
`define CTRL_RESET          32'h0000_0000
`define ST_FAULT            0
`define ST_OVERLOAD         1
`define ST_WARNING          2
`define ST_RUNNING          3
`define ST_ATTAINED         4
`define ST_CLAMPING         5
`define ST_BUSY             6
`define ST_MAINPWR          7
`define ST_DIR              8
`define ST_BRAKE            9
`define ST_COAST            10
`define ST_QSTOP            11
`define ST_LATCHED          12
`endif

// ### rtl/in_sync.v
// two-flop synchroniser bank for the photocoupled and status inputs
// assumes inputs may change at any time relative to the core clock
`timescale 1ns/1ps
`include "motor_io_map.vh"
module in_sync #(
  parameter WIDTH = 16
) (
  input  wire             clk_i,
  input  wire             rst_i,
  input  wire             ce_i,
  input  wire [WIDTH-1:0] d_i,
  output reg  [WIDTH-1:0] q_o
);
  reg [WIDTH-1:0] meta;
  genvar g;
  generate
    for (g = 0; g < WIDTH; g = g + 1)
    begin : bit_sync
      always @(posedge clk_i)
      begin
        if (rst_i)
        begin
          meta[g] <= 1'b0;
          q_o[g]  <= 1'b0;
        end
        else if (ce_i)
        begin
          meta[g] <= d_i[g];
          q_o[g]  <= meta[g];
        end
      end
    end
  endgenerate
endmodule // in_sync

// ### rtl/speed_pulse.v
// speed pulse generator: fixed-width pulse per shaft tick
// assumes tick_i is a one-cycle pulse, 30 per output revolution, from the commutation logic
`timescale 1ns/1ps
`include "motor_io_map.vh"
module speed_pulse (
  input  wire clk_i,
  input  wire rst_i,
  input  wire ce_i,
  input  wire tick_i,
  output reg  pulse_o
);
  reg [15:0] count;
  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      count   <= 16'h0000;
      pulse_o <= 1'b0;
    end
    else if (ce_i)
    begin
      // a tick inside a pulse restarts it; ticks never come that fast below top speed
      if (tick_i)
      begin
        count   <= `PULSE_LOAD;
        pulse_o <= 1'b1;
      end
      else if (count != 16'h0000)
        count <= count - 16'h0001;
      else
        pulse_o <= 1'b0;
    end
  end
endmodule // speed_pulse

// ### rtl/motor_status_io.v
// Functional notes
// - torque limiting follows the clamp enable input: on enables, off disables
// - unmapped clamp enable reads on; several mapped terminals must all be on
// - thirty speed pulses per output revolution, each 0.2 ms wide
// - a protective trip drives the fault output off and blinks the alarm lamp
// - alarm: standard motor coasts; brake motor stops instantly and brakes
// - brake motor option: brake at alarm, or only after coasting to stop
// - alarm clear is ignored while either run input is on
// - running output is on while any run input is on
// - speed attained output on while a run input is on and measured speed reaches commanded speed
// - with warning enabled, overload output goes off above warning level
// - overload alarm drives overload output off even with warning disabled
// - warning output follows warning cause; motor keeps running
// - clamping output on while torque has reached the limit
// - busy output on during internal processing and maintenance commands
// - main power output on while main supply is present
// - shaft sense output on for forward, off for reverse
// - echo outputs mirror run, stop method, brake, unlock, speed select, clamp
// - pass-through bit: network command bit drives direct output
// - pass-through bit: direct input, per contact sense, reported to network
// - resettable alarm clears on the falling edge of alarm clear after it has been held on for 10 ms
// - both run inputs on together stop the motor instantly
//
// top of the motor status and control logic, APB slave for configuration
// assumes all inputs synchronous-in-spirit but asynchronous in fact; one 40 MHz clock
`timescale 1ns/1ps
`include "motor_io_map.vh"
module motor_status_io (
  input  wire        CORE_CLK_I,
  input  wire        SYS_RST_I,
  input  wire        CLK_EN_I,
  input  wire        PSEL_I,
  input  wire        PENABLE_I,
  input  wire        PWRITE_I,
  input  wire [11:0] PADDR_I,
  input  wire [31:0] PWDATA_I,
  output reg  [31:0] PRDATA_O,
  output reg         PREADY_O,
  output reg         PSLVERR_O,
  input  wire        CLOCKWISE_RUN_I,
  input  wire        COUNTERCLOCKWISE_RUN_I,
  input  wire        STOP_METHOD_I,
  input  wire        BRAKE_RELEASE_I,
  input  wire        OPERATOR_TOOL_UNLOCK_I,
  input  wire [3:0]  SPEED_SELECT_I,
  input  wire        TORQUE_CLAMP_ENABLE_I,
  input  wire        ALARM_CLEAR_I,
  input  wire [6:0]  DIRECT_INPUT_I,
  input  wire        PROTECT_TRIP_I,
  input  wire        TRIP_RESETTABLE_I,
  input  wire        OVERLOAD_ALARM_I,
  input  wire        OVERLOAD_LEVEL_I,
  input  wire        WARNING_CAUSE_I,
  input  wire        TORQUE_AT_LIMIT_I,
  input  wire        MAINT_CMD_I,
  input  wire        INTERNAL_BUSY_I,
  input  wire        MAIN_POWER_I,
  input  wire        SHAFT_FORWARD_I,
  input  wire        SHAFT_TICK_I,
  input  wire        MOTOR_STOPPED_I,
  input  wire [15:0] MEASURED_SPEED_I,
  output reg         TORQUE_LIMIT_EN_O,
  output reg         SPEED_PULSE_O,
  output reg         PRIMARY_FAULT_OUTPUT_O,
  output reg         ALARM_LAMP_O,
  output reg         OVERLOAD_OUTPUT_O,
  output reg         WARNING_FLAG_O,
  output reg         MOTOR_RUNNING_O,
  output reg         SPEED_ATTAINED_O,
  output reg         TORQUE_CLAMPING_ACTIVE_O,
  output reg         DRIVER_PROCESSING_O,
  output reg         MAIN_POWER_PRESENT_O,
  output reg         SHAFT_SENSE_O,
  output reg         COAST_O,
  output reg         QUICK_STOP_O,
  output reg         BRAKE_ENGAGE_O,
  output reg  [1:0]  DIRECT_OUTPUT_O,
  output reg  [10:0] ECHO_O
);
  localparam ALM_IDLE  = 3'b001;
  localparam ALM_ARMED = 3'b010;
  localparam ALM_HELD  = 3'b100;

  // synchronised input bundle
  wire [19:0] raw_in = {DIRECT_INPUT_I, ALARM_CLEAR_I, TORQUE_CLAMP_ENABLE_I, SPEED_SELECT_I,
                        OPERATOR_TOOL_UNLOCK_I, BRAKE_RELEASE_I, STOP_METHOD_I,
                        COUNTERCLOCKWISE_RUN_I, CLOCKWISE_RUN_I, PROTECT_TRIP_I, SHAFT_FORWARD_I};
  wire [19:0] sin;
  in_sync #(.WIDTH(20)) u_sync (
    .clk_i (CORE_CLK_I),
    .rst_i (SYS_RST_I),
    .ce_i  (CLK_EN_I),
    .d_i   (raw_in),
    .q_o   (sin)
  );

  wire       s_fwd_shaft = sin[0];
  wire       s_trip      = sin[1];
  wire       s_cw        = sin[2];
  wire       s_ccw       = sin[3];
  wire       s_stop_m    = sin[4];
  wire       s_brake_rel = sin[5];
  wire       s_unlock    = sin[6];
  wire [3:0] s_speed_sel = sin[10:7];
  wire       s_clamp     = sin[11];
  wire       s_clear     = sin[12];
  wire [6:0] s_direct    = sin[19:13];

  // configuration registers
  reg [31:0] ctrl;
  reg [15:0] clamp_map;   // [0] direct terminal mapped, [1] network terminal mapped, [2] network bit
  reg [15:0] net_cmd;
  reg [31:0] pass_map;
  reg [15:0] speed_cmd;
  reg [15:0] net_stat;

  // alarm state
  reg        alarm;
  reg        alarm_brake_late;
  reg [2:0]  alm_state;
  reg [18:0] hold_cnt;
  reg        clear_prev;
  reg [23:0] blink_cnt;

  wire run_any  = s_cw | s_ccw;
  wire both_run = s_cw & s_ccw;

  // all mapped terminals must be on; none mapped reads on
  function clamp_on;
    input [15:0] map;
    input        direct_bit;
    begin
      clamp_on = (~map[0] | direct_bit) & (~map[1] | map[2]);
    end
  endfunction

  // pass map: bits [2:0] direct input index, [4] contact inverted, [5] routing enable
  function sense_in;
    input [6:0] pins;
    input [5:0] cfg;
    begin
      sense_in = cfg[5] & (pins[cfg[2:0]] ^ cfg[4]);
    end
  endfunction

  wire apb_setup  = PSEL_I & ~PENABLE_I;
  wire apb_access = PSEL_I & PENABLE_I & PREADY_O;
  wire wr_en      = apb_access & PWRITE_I;

  function addr_known;
    input [11:0] a;
    begin
      addr_known = (a == `ADDR_CTRL) | (a == `ADDR_CLAMP_MAP) | (a == `ADDR_NET_CMD) |
                   (a == `ADDR_PASS_MAP) | (a == `ADDR_STATUS) | (a == `ADDR_NET_STAT) |
                   (a == `ADDR_ECHO) | (a == `ADDR_SPEED_CMD);
    end
  endfunction

  wire [15:0] status_word = {3'b000, alarm, QUICK_STOP_O, COAST_O, BRAKE_ENGAGE_O, SHAFT_SENSE_O,
                             MAIN_POWER_PRESENT_O, DRIVER_PROCESSING_O, TORQUE_CLAMPING_ACTIVE_O,
                             SPEED_ATTAINED_O, MOTOR_RUNNING_O, WARNING_FLAG_O, OVERLOAD_OUTPUT_O,
                             PRIMARY_FAULT_OUTPUT_O};

  reg [31:0] rd_mux;
  always @*
  begin
    rd_mux = 32'h0000_0000;
    case (PADDR_I)
      `ADDR_CTRL:      rd_mux = ctrl;
      `ADDR_CLAMP_MAP: rd_mux = {16'h0000, clamp_map};
      `ADDR_NET_CMD:   rd_mux = {16'h0000, net_cmd};
      `ADDR_PASS_MAP:  rd_mux = pass_map;
      `ADDR_STATUS:    rd_mux = {16'h0000, status_word};
      `ADDR_NET_STAT:  rd_mux = {16'h0000, net_stat};
      `ADDR_ECHO:      rd_mux = {21'h00000, ECHO_O};
      `ADDR_SPEED_CMD: rd_mux = {16'h0000, speed_cmd};
      default:         rd_mux = 32'h0000_0000;
    endcase
  end

  // apb slave: no wait state, answer registered
  always @(posedge CORE_CLK_I)
  begin
    if (SYS_RST_I)
    begin
      PREADY_O  <= 1'b0;
      PRDATA_O  <= 32'h0000_0000;
      PSLVERR_O <= 1'b0;
      ctrl      <= `CTRL_RESET;
      clamp_map <= 16'h0000;
      net_cmd   <= 16'h0000;
      pass_map  <= 32'h0000_0000;
      speed_cmd <= 16'h0000;
    end
    else if (CLK_EN_I)
    begin
      PREADY_O  <= apb_setup;
      PRDATA_O  <= apb_setup ? rd_mux : PRDATA_O;
      PSLVERR_O <= apb_setup & ~addr_known(PADDR_I);
      if (wr_en)
      begin
        case (PADDR_I)
          `ADDR_CTRL:      ctrl      <= PWDATA_I;
          `ADDR_CLAMP_MAP: clamp_map <= PWDATA_I[15:0];
          `ADDR_NET_CMD:   net_cmd   <= PWDATA_I[15:0];
          `ADDR_PASS_MAP:  pass_map  <= PWDATA_I;
          `ADDR_SPEED_CMD: speed_cmd <= PWDATA_I[15:0];
          default:         ctrl      <= ctrl;
        endcase
      end
    end
  end

  wire clear_fall = clear_prev & ~s_clear;
  wire hold_done  = (hold_cnt == `CLEAR_HOLD_LIMIT);

  // alarm latch and clear handshake
  always @(posedge CORE_CLK_I)
  begin
    if (SYS_RST_I)
    begin
      alarm            <= 1'b0;
      alarm_brake_late <= 1'b0;
      alm_state        <= ALM_IDLE;
      hold_cnt         <= 19'h00000;
      clear_prev       <= 1'b0;
      blink_cnt        <= 24'h000000;
    end
    else if (CLK_EN_I)
    begin
      clear_prev <= s_clear;
      blink_cnt  <= alarm ? blink_cnt + 24'h000001 : 24'h000000;
      case (alm_state)
        ALM_IDLE:
        begin
          hold_cnt <= 19'h00000;
          if (alarm & s_clear & ~run_any)
            alm_state <= ALM_ARMED;
        end
        ALM_ARMED:
        begin
          if (run_any | ~s_clear)
          begin
            alm_state <= ALM_IDLE;
            hold_cnt  <= 19'h00000;
          end
          else if (hold_done)
            alm_state <= ALM_HELD;
          else
            hold_cnt <= hold_cnt + 19'h00001;
        end
        ALM_HELD:
        begin
          if (run_any)
            alm_state <= ALM_IDLE;
          else if (clear_fall)
          begin
            alm_state <= ALM_IDLE;
            if (TRIP_RESETTABLE_I & ~s_trip)
              alarm <= 1'b0;
          end
        end
        default: alm_state <= ALM_IDLE;
      endcase
      // a new trip wins over a clear in the same cycle
      if (s_trip | OVERLOAD_ALARM_I)
      begin
        alarm            <= 1'b1;
        alarm_brake_late <= ctrl[`CTRL_BRAKE_AFTER];
      end
    end
  end

  wire speed_pulse_w;
  speed_pulse u_pulse (
    .clk_i   (CORE_CLK_I),
    .rst_i   (SYS_RST_I),
    .ce_i    (CLK_EN_I),
    .tick_i  (SHAFT_TICK_I),
    .pulse_o (speed_pulse_w)
  );

  integer k;
  reg [1:0]  next_direct;
  reg [15:0] next_net_stat;
  always @*
  begin
    next_direct   = 2'b00;
    next_net_stat = 16'h0000;
    for (k = 0; k < 2; k = k + 1)
      next_direct[k] = pass_map[16 + k] & net_cmd[k];
    for (k = 0; k < 2; k = k + 1)
      next_net_stat[14 + k] = sense_in(s_direct, pass_map[6*k +: 6]);
  end

  wire brake_motor = ctrl[`CTRL_BRAKE_MOTOR];

  // status outputs, all registered
  always @(posedge CORE_CLK_I)
  begin
    if (SYS_RST_I)
    begin
      TORQUE_LIMIT_EN_O        <= 1'b0;
      SPEED_PULSE_O            <= 1'b0;
      PRIMARY_FAULT_OUTPUT_O   <= 1'b0;
      ALARM_LAMP_O             <= 1'b0;
      OVERLOAD_OUTPUT_O        <= 1'b0;
      WARNING_FLAG_O           <= 1'b0;
      MOTOR_RUNNING_O          <= 1'b0;
      SPEED_ATTAINED_O         <= 1'b0;
      TORQUE_CLAMPING_ACTIVE_O <= 1'b0;
      DRIVER_PROCESSING_O      <= 1'b0;
      MAIN_POWER_PRESENT_O     <= 1'b0;
      SHAFT_SENSE_O            <= 1'b0;
      COAST_O                  <= 1'b0;
      QUICK_STOP_O             <= 1'b0;
      BRAKE_ENGAGE_O           <= 1'b0;
      DIRECT_OUTPUT_O          <= 2'b00;
      ECHO_O                   <= 11'h000;
      net_stat                 <= 16'h0000;
    end
    else if (CLK_EN_I)
    begin
      TORQUE_LIMIT_EN_O        <= clamp_on(clamp_map, s_clamp);
      SPEED_PULSE_O            <= speed_pulse_w;
      PRIMARY_FAULT_OUTPUT_O   <= ~alarm;
      ALARM_LAMP_O             <= alarm & blink_cnt[23];
      OVERLOAD_OUTPUT_O        <= ~((ctrl[`CTRL_OVL_WARN_EN] & OVERLOAD_LEVEL_I)
                                    | OVERLOAD_ALARM_I);
      WARNING_FLAG_O           <= WARNING_CAUSE_I;
      MOTOR_RUNNING_O          <= run_any;
      SPEED_ATTAINED_O         <= run_any & (MEASURED_SPEED_I >= speed_cmd);
      TORQUE_CLAMPING_ACTIVE_O <= TORQUE_AT_LIMIT_I;
      DRIVER_PROCESSING_O      <= INTERNAL_BUSY_I | MAINT_CMD_I;
      MAIN_POWER_PRESENT_O     <= MAIN_POWER_I;
      SHAFT_SENSE_O            <= s_fwd_shaft;
      COAST_O                  <= alarm & (~brake_motor | alarm_brake_late);
      QUICK_STOP_O             <= both_run | (alarm & brake_motor & ~alarm_brake_late);
      // brake released by the release input outside an alarm, and during a late-brake alarm until the motor stops
      BRAKE_ENGAGE_O           <= alarm ? (~alarm_brake_late | MOTOR_STOPPED_I)
                                        : ~s_brake_rel;
      DIRECT_OUTPUT_O          <= next_direct;
      net_stat                 <= next_net_stat;
      ECHO_O                   <= {s_clamp, s_speed_sel, s_unlock, s_brake_rel, s_stop_m,
                                   s_ccw, s_cw, run_any};
    end
  end
endmodule // motor_status_io

// ### testbench/motor_status_io_asserts.sv
// port-level checks of the motor status and control logic
// assumes one 40 MHz clock and a synchronous active-high reset; bound below
`timescale 1ns/1ps
module motor_status_io_asserts (
  input logic        CORE_CLK_I,
  input logic        SYS_RST_I,
  input logic        CLK_EN_I,
  input logic        CLOCKWISE_RUN_I,
  input logic        COUNTERCLOCKWISE_RUN_I,
  input logic        STOP_METHOD_I,
  input logic        BRAKE_RELEASE_I,
  input logic        OPERATOR_TOOL_UNLOCK_I,
  input logic [3:0]  SPEED_SELECT_I,
  input logic        TORQUE_CLAMP_ENABLE_I,
  input logic        PROTECT_TRIP_I,
  input logic        OVERLOAD_ALARM_I,
  input logic        WARNING_CAUSE_I,
  input logic        TORQUE_AT_LIMIT_I,
  input logic        MAINT_CMD_I,
  input logic        INTERNAL_BUSY_I,
  input logic        MAIN_POWER_I,
  input logic        SHAFT_FORWARD_I,
  input logic        SHAFT_TICK_I,
  input logic        SPEED_PULSE_O,
  input logic        PRIMARY_FAULT_OUTPUT_O,
  input logic        OVERLOAD_OUTPUT_O,
  input logic        WARNING_FLAG_O,
  input logic        MOTOR_RUNNING_O,
  input logic        TORQUE_CLAMPING_ACTIVE_O,
  input logic        DRIVER_PROCESSING_O,
  input logic        MAIN_POWER_PRESENT_O,
  input logic        SHAFT_SENSE_O,
  input logic [10:0] ECHO_O
);
  logic [2:0]  age;
  logic [13:0] since_tick;
  logic [9:0]  in_vec;
  logic        busy_in;
  assign in_vec  = {TORQUE_CLAMP_ENABLE_I, SPEED_SELECT_I, OPERATOR_TOOL_UNLOCK_I, BRAKE_RELEASE_I,
                    STOP_METHOD_I, COUNTERCLOCKWISE_RUN_I, CLOCKWISE_RUN_I};
  assign busy_in = INTERNAL_BUSY_I | MAINT_CMD_I;
  // age keeps $past away from values taken during reset
  always_ff @(posedge CORE_CLK_I)
    if (SYS_RST_I)
      age <= 3'h0;
    else if (CLK_EN_I && age != 3'h7)
      age <= age + 3'h1;
  always_ff @(posedge CORE_CLK_I)
    if (SYS_RST_I)
      since_tick <= 14'h3FFF;
    else if (CLK_EN_I && SHAFT_TICK_I)
      since_tick <= 14'h0;
    else if (CLK_EN_I && since_tick != 14'h3FFF)
      since_tick <= since_tick + 14'h1;
  default clocking cb @(posedge CORE_CLK_I); endclocking
  default disable iff (SYS_RST_I || !CLK_EN_I);
  sequence s_trip;
    $rose(PROTECT_TRIP_I);
  endsequence
  sequence s_tick;
    $rose(SHAFT_TICK_I);
  endsequence
  property p_pulse_start;
    s_tick |-> ##[1:3] SPEED_PULSE_O;
  endproperty
  a_run_follow:
    assert property (age > 3'h3 |-> MOTOR_RUNNING_O == (($past(in_vec, 3) & 10'h3) != 10'h0))
    else $error("running output does not follow run inputs");
  a_echo_mirror:
    assert property (age > 3'h3 |-> ECHO_O[10:1] == $past(in_vec, 3) && ECHO_O[0] == MOTOR_RUNNING_O)
    else $error("echo outputs do not mirror inputs");
  a_shaft_sense:
    assert property (age > 3'h3 |-> SHAFT_SENSE_O == $past(SHAFT_FORWARD_I, 3))
    else $error("shaft sense does not follow direction");
  a_warn_follow:
    assert property (age > 3'h3 |-> WARNING_FLAG_O == $past(WARNING_CAUSE_I))
    else $error("warning output does not follow cause");
  a_busy_follow:
    assert property (age > 3'h3 && busy_in |=> DRIVER_PROCESSING_O)
    else $error("busy output missing");
  a_power_follow:
    assert property (age > 3'h3 |-> ##1 MAIN_POWER_PRESENT_O == $past(MAIN_POWER_I))
    else $error("main power output wrong");
  a_clamp_active:
    assert property ($fell(TORQUE_AT_LIMIT_I) |=> !TORQUE_CLAMPING_ACTIVE_O)
    else $error("clamping output stays on");
  a_trip_fault:
    assert property (s_trip |-> ##4 !PRIMARY_FAULT_OUTPUT_O)
    else $error("fault output not off after trip");
  a_ovl_alarm:
    assert property (OVERLOAD_ALARM_I |=> !OVERLOAD_OUTPUT_O)
    else $error("overload output not off on overload alarm");
  a_pulse_start:
    assert property (p_pulse_start)
    else $error("speed pulse did not start");
  a_pulse_width:
    assert property ($fell(SPEED_PULSE_O) |-> since_tick >= 14'h1F40 && since_tick <= 14'h1F42)
    else $error("speed pulse width wrong");
endmodule // motor_status_io_asserts
bind motor_status_io motor_status_io_asserts chk_u (.*);

// ### testbench/run_controller.sv
// external controller model for the run and alarm-clear inputs
// assumes requests from the bench; changes only after rising edges
`timescale 1ns/1ps
module run_controller #(
  parameter int HOLD = 400000
) (
  input  logic clk_i,
  input  logic rst_i,
  input  logic go_cw_i,
  input  logic go_ccw_i,
  input  logic want_clear_i,
  output logic cw_o,
  output logic ccw_o,
  output logic clear_o
);
  int held;
  always_ff @(posedge clk_i)
    if (rst_i)
    begin
      cw_o    <= 1'h0;
      ccw_o   <= 1'h0;
      clear_o <= 1'h0;
      held    <= 0;
    end
    else if (want_clear_i || clear_o)
    begin
      // runs drop first; clear is held for the full time once raised
      cw_o    <= 1'h0;
      ccw_o   <= 1'h0;
      clear_o <= !(cw_o || ccw_o) && (want_clear_i || held < HOLD);
      held    <= clear_o ? held + 1 : 0;
    end
    else
    begin
      cw_o  <= go_cw_i;
      ccw_o <= go_ccw_i;
    end
endmodule // run_controller

// ### testbench/tb_motor_status_io.sv
// self-checking bench for the motor status and control logic
// assumes the run controller model and the bound port checker
`timescale 1ns/1ps
`include "motor_io_map.vh"
module tb_motor_status_io;
  logic        clk = 0, rst = 1, psel = 0, pen = 0, pwr = 0, pready, pslverr, err;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, rdat;
  logic        go_cw = 0, go_ccw = 0, want_clr = 0, cw, ccw, clr;
  logic        stop = 0, brel = 0, unlk = 0, tce = 0, trip = 0, ovla = 0, ovll = 0;
  logic        warn = 0, tlim = 0, maint = 0, mpwr = 0, sfwd = 0, tick = 0, mstop = 0, ibsy = 0;
  logic [3:0]  sel = 0;
  logic [6:0]  din = 0;
  logic [15:0] mspd = 0;
  logic        tle, spo, flt, lamp, ovo, warning_flag, run, att, tca, bsy, mpo, dir, cst, qst, brk;
  logic [1:0]  dout;
  logic [10:0] echo;
  int          n_mismatch = 0, checks_done = 0, cyc = 0;
  motor_status_io dut_u (
    .CORE_CLK_I(clk), .SYS_RST_I(rst), .CLK_EN_I(1'h1), .PSEL_I(psel), .PENABLE_I(pen), .PWRITE_I(pwr),
    .PADDR_I(paddr), .PWDATA_I(pwdata), .PRDATA_O(prdata), .PREADY_O(pready), .PSLVERR_O(pslverr),
    .CLOCKWISE_RUN_I(cw), .COUNTERCLOCKWISE_RUN_I(ccw), .STOP_METHOD_I(stop), .BRAKE_RELEASE_I(brel),
    .OPERATOR_TOOL_UNLOCK_I(unlk), .SPEED_SELECT_I(sel), .TORQUE_CLAMP_ENABLE_I(tce), .ALARM_CLEAR_I(clr),
    .DIRECT_INPUT_I(din), .PROTECT_TRIP_I(trip), .TRIP_RESETTABLE_I(1'h1), .OVERLOAD_ALARM_I(ovla),
    .OVERLOAD_LEVEL_I(ovll), .WARNING_CAUSE_I(warn), .TORQUE_AT_LIMIT_I(tlim), .MAINT_CMD_I(maint),
    .INTERNAL_BUSY_I(ibsy), .MAIN_POWER_I(mpwr), .SHAFT_FORWARD_I(sfwd), .SHAFT_TICK_I(tick),
    .MOTOR_STOPPED_I(mstop), .MEASURED_SPEED_I(mspd), .TORQUE_LIMIT_EN_O(tle), .SPEED_PULSE_O(spo),
    .PRIMARY_FAULT_OUTPUT_O(flt), .ALARM_LAMP_O(lamp), .OVERLOAD_OUTPUT_O(ovo), .WARNING_FLAG_O(warning_flag),
    .MOTOR_RUNNING_O(run), .SPEED_ATTAINED_O(att), .TORQUE_CLAMPING_ACTIVE_O(tca),
    .DRIVER_PROCESSING_O(bsy), .MAIN_POWER_PRESENT_O(mpo), .SHAFT_SENSE_O(dir), .COAST_O(cst),
    .QUICK_STOP_O(qst), .BRAKE_ENGAGE_O(brk), .DIRECT_OUTPUT_O(dout), .ECHO_O(echo));
  run_controller ctl_u (.clk_i(clk), .rst_i(rst), .go_cw_i(go_cw), .go_ccw_i(go_ccw),
    .want_clear_i(want_clr), .cw_o(cw), .ccw_o(ccw), .clear_o(clr));
  initial
    forever #12.5 clk = ~clk;
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 60000)
    begin
      n_mismatch++;
      conclude();
    end
  end
  task automatic conclude();
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask
  // one transfer; the request stands until pready is sampled high
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    psel   <= 1'h1;
    pwr    <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1'h1;
    do @(posedge clk); while (pready !== 1'h1);
    rdat = prdata;
    err  = pslverr;
    psel <= 1'h0;
    pen  <= 1'h0;
  endtask
  task automatic do_reset();
    rst <= 1'h1;
    repeat (16) @(posedge clk);
    rst <= 1'h0;
    repeat (4) @(posedge clk);
  endtask
  task automatic t_regs();
    apb(0, `ADDR_CTRL, 0);
    chk("ctrl reset", `CTRL_RESET, rdat);
    apb(1, `ADDR_CTRL, 32'h7);
    apb(0, `ADDR_CTRL, 0);
    chk("ctrl rw", 32'h7, rdat);
    apb(0, 12'hFFC, 32'hFFFF_FFFF);
    chk("unmapped err", 32'h1, err);
    chk("unmapped data", 32'h0, rdat);
    apb(1, `ADDR_CTRL, 0);
  endtask
  task automatic t_status();
    apb(1, `ADDR_SPEED_CMD, 32'h100);
    for (int v = 1; v >= 0; v--)
    begin
      {warn, tlim, maint, mpwr, sfwd, go_cw} <= {6{v[0]}};
      mspd <= v[0] ? 16'h100 : 16'hFF;
      repeat (6) @(posedge clk);
      chk("running", v, run);
      chk("attained", v, att);
      chk("warning", v, warning_flag);
      chk("clamping", v, tca);
      chk("busy", v, bsy);
      chk("main power", v, mpo);
      chk("shaft sense", v, dir);
    end
    ibsy <= 1'h1;
    repeat (2) @(posedge clk);
    chk("busy internal", 1, bsy);
    ibsy <= 1'h0;
  endtask
  task automatic t_echo();
    logic [9:0] v;
    for (int i = 0; i < 10; i++)
    begin
      v = 10'h1 << i;
      {tce, sel, unlk, brel, stop, go_ccw, go_cw} <= v;
      repeat (6) @(posedge clk);
      chk("echo", {v, v[1] | v[0]}, echo);
    end
    {go_ccw, go_cw} <= 2'h3;
    repeat (6) @(posedge clk);
    chk("both runs stop", 1, qst);
    {tce, sel, unlk, brel, stop, go_ccw, go_cw} <= 10'h0;
  endtask
  task automatic t_clamp();
    logic [4:0] c[6] = '{5'h01, 5'h07, 5'h04, 5'h0E, 5'h1F, 5'h1C};
    for (int i = 0; i < 6; i++)
    begin
      apb(1, `ADDR_CLAMP_MAP, {29'h0, c[i][4:2]});
      tce <= c[i][1];
      repeat (6) @(posedge clk);
      chk("clamp enable", c[i][0], tle);
    end
  endtask
  task automatic t_overload();
    logic [3:0] c[4] = '{4'h5, 4'hC, 4'h9, 4'h2};
    for (int i = 0; i < 4; i++)
    begin
      apb(1, `ADDR_CTRL, {31'h0, c[i][3]});
      {ovll, ovla} <= c[i][2:1];
      repeat (6) @(posedge clk);
      chk("overload out", c[i][0], ovo);
    end
    ovla <= 1'h0;
  endtask
  task automatic t_pass();
    for (int i = 0; i < 4; i++)
    begin
      apb(1, `ADDR_PASS_MAP, i[1] ? 32'h0001_0D80 : 32'h0001_0980);
      apb(1, `ADDR_NET_CMD, {31'h0, i[0]});
      din <= {i[0], 6'h0};
      repeat (6) @(posedge clk);
      chk("direct out", i[0], dout[0]);
      chk("direct out1", 0, dout[1]);
      apb(0, `ADDR_NET_STAT, 0);
      chk("net status", i[0] ^ i[1], rdat[15]);
    end
  endtask
  task automatic t_speed();
    int w;
    w = 0;
    tick <= 1'h1;
    @(posedge clk);
    tick <= 1'h0;
    repeat (8100)
    begin
      @(posedge clk);
      w += (spo === 1'h1);
    end
    chk("pulse width", `PULSE_CYCLES, w);
  endtask
  task automatic t_alarm(input logic [2:0] cfg);
    do_reset();
    apb(1, `ADDR_CTRL, {29'h0, cfg});
    mstop <= 1'h0;
    trip  <= 1'h1;
    repeat (6) @(posedge clk);
    trip <= 1'h0;
    chk("fault out", 0, flt);
    chk("coast", cfg != 3'h4, cst);
    chk("brake", !cfg[1], brk);
    chk("quick stop", cfg == 3'h4, qst);
    chk("lamp dark", 0, lamp);
    mstop <= 1'h1;
    repeat (4) @(posedge clk);
    chk("brake stopped", 1, brk);
    // alarm must hold while the clear line is still on
    go_cw    <= 1'h1;
    want_clr <= 1'h1;
    repeat (8) @(posedge clk);
    chk("fault held", 0, flt);
    {go_cw, want_clr} <= 2'h0;
  endtask
  initial
  begin
    do_reset();
    t_regs();
    t_status();
    t_echo();
    t_clamp();
    t_overload();
    t_pass();
    t_speed();
    t_alarm(3'h0);
    t_alarm(3'h4);
    t_alarm(3'h6);
    conclude();
  end
endmodule // tb_motor_status_io
